// *** include/tpg_pkg.sv ***
// Purpose: shared constants and types for the link test-pattern generator
// Assumes: one octet per lane per clock, 16 lanes (8 in group a, 8 in group b)
// Notes: test mode codes are local encodings of the selection field
package tpg_pkg;
  localparam int LANES = 16;
  localparam int GROUP_LANES = 8;
  localparam int RPAT_LEN = 12;
  localparam int N8_FRAME_OCTETS = 1;
  localparam int N12_FRAME_OCTETS = 8;

  localparam logic [7:0] D21_5 = 8'hB5;
  localparam logic [7:0] K28_5 = 8'hBC;
  localparam logic [3:0] TAIL_NIBBLE = 4'h0;
  localparam logic [7:0] N8_BASE_SECOND = 8'hFF;

  typedef enum logic [2:0] {
    TM_OFF = 3'h0,
    TM_SHORT = 3'h1,
    TM_D21 = 3'h2,
    TM_K28 = 3'h3,
    TM_ILA = 3'h4,
    TM_RPAT = 3'h5
  } test_mode_t;

  localparam logic [7:0] RPAT_TABLE [RPAT_LEN] = '{
    8'hBE, 8'hD7, 8'h23, 8'h47, 8'h6B, 8'h8F,
    8'hB3, 8'h14, 8'h5E, 8'hFB, 8'h35, 8'h59
  };
endpackage

// *** design/tpg_buf2.sv ***
// Purpose: two-entry skid buffer with valid and ready on both sides
// Assumes: single clock, synchronous active-high reset
// Notes: in_ready depends only on occupancy, so a stalled sink fills it
`timescale 1ns/1ns
module tpg_buf2 #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  typedef struct packed {
    logic [1:0] cnt;
    logic [WIDTH-1:0] e0;
    logic [WIDTH-1:0] e1;
  } buf_state_t;

  buf_state_t st_ff;
  buf_state_t nxt_st;
  logic push;
  logic pop;

  always_comb
  begin
    nxt_st = st_ff;
    push = in_valid && (st_ff.cnt != 2'h2);
    pop = out_ready && (st_ff.cnt != 2'h0);
    if (pop)
    begin
      nxt_st.e0 = st_ff.e1;
    end
    if (push)
    begin
      if (st_ff.cnt == 2'h0 || (st_ff.cnt == 2'h1 && pop))
      begin
        nxt_st.e0 = in_data;
      end
      else
      begin
        nxt_st.e1 = in_data;
      end
    end
    nxt_st.cnt = st_ff.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign in_ready = (st_ff.cnt != 2'h2);
  assign out_valid = (st_ff.cnt != 2'h0);
  assign out_data = st_ff.e0;
endmodule

// *** design/jesd_link_test_pattern_gen.sv ***
// Purpose: transmit-side test-pattern inserter for a 16-lane serial converter link
// Assumes: one octet per lane per clock; link layer status arrives as levels
// Notes: ila_repeat and restart_cgs steer the link layer; octets go out through a buffer
//
// Operation
// - transport patterns are built the same way for 8b/10b and 64b/66b links.
// - with 8b/10b, transport patterns start after the alignment sequence and repeat in data state.
// - with 64b/66b, transport patterns start once the serializers are initialised.
// - every lane mode uses the short transport pattern, repeating each frame for 12-bit samples and every two frames for 8-bit; no long one exists.
// - for 8-bit samples lanes 0..3 of each group send 00..03 then FF..FC over two frames.
// - only the lowest lanes enabled by the lane mode carry the pattern; the rest stay idle.
// - for 12-bit samples with 8-octet frames lane k of each group sends words (F-k,k,j) j=1..5 then a tail nibble.
// - the D21.5 mode sends an unbroken D21.5 stream on every active lane for either encoding.
// - the K28.5 mode sends an unbroken K28.5 stream, 8b/10b only.
// - the repeated alignment mode keeps the link layer resending the alignment sequence, 8b/10b only.
// - in that mode a receiver sync request restarts code group sync, then alignment resumes.
// - the RPAT mode feeds the encoder of each active lane the 12-octet modified RPAT sequence, 8b/10b only.
// - a selection field picks the test mode while lane power and rate follow the lane mode.
`timescale 1ns/1ns
module jesd_link_test_pattern_gen #(
  parameter int LANES = tpg_pkg::LANES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] test_pattern_select,
  input wire logic enc_64b66b,
  input wire logic n12_mode,
  input wire logic [4:0] active_lanes,
  input wire logic serdes_ready,
  input wire logic ila_done,
  input wire logic data_enc_state,
  input wire logic sync_request,
  input wire logic [LANES*8-1:0] sample_octets,
  input wire logic sample_valid,
  output logic sample_ready,
  output logic [LANES*8-1:0] lane_octets,
  output logic lane_valid,
  input wire logic lane_ready,
  output logic [LANES-1:0] lane_is_k,
  output logic ila_repeat,
  output logic restart_cgs
);
  typedef struct packed {
    logic [3:0] rpat_idx;
    logic [2:0] oct_idx;
    logic frame_ph;
    logic [LANES*8-1:0] word;
    logic [LANES-1:0] k;
    logic valid;
    logic ila_rep;
    logic cgs;
  } gen_state_t;

  gen_state_t st_ff;
  gen_state_t nxt_st;
  tpg_pkg::test_mode_t mode;
  logic tp_run;
  logic buf_in_ready;
  logic [LANES*8+LANES-1:0] buf_out;
  logic [LANES-1:0] lane_en;
  logic [7:0] oct;
  logic [3:0] kk;
  logic [47:0] wbits;
  int g;

  // note: the 12-bit pattern needs a frame aligned counter, hence oct_idx
  always_comb
  begin
    nxt_st = st_ff;
    mode = tpg_pkg::test_mode_t'(test_pattern_select);
    // start condition depends only on the encoding
    tp_run = enc_64b66b ? serdes_ready : (ila_done && data_enc_state);
    oct = 8'h00;
    kk = 4'h0;
    wbits = '0;
    for (g = 0; g < LANES; g++)
    begin
      lane_en[g] = (g < int'(active_lanes));
    end
    nxt_st.ila_rep = (mode == tpg_pkg::TM_ILA) && !enc_64b66b;
    nxt_st.cgs = nxt_st.ila_rep && sync_request;
    // a full buffer leaves the staged word in place, so a stall loses nothing
    if (buf_in_ready)
    begin
      nxt_st.valid = 1'b0;
      nxt_st.k = '0;
      nxt_st.word = '0;
      unique case (mode)
        tpg_pkg::TM_OFF:
        begin
          nxt_st.word = sample_octets;
          nxt_st.valid = sample_valid;
        end
        tpg_pkg::TM_SHORT:
        begin
          nxt_st.valid = tp_run;
          for (g = 0; g < LANES; g++)
          begin
            if (!n12_mode)
            begin
              // lanes 4..7 of each group repeat the octets of lanes 0..3
              oct = st_ff.frame_ph ? tpg_pkg::N8_BASE_SECOND - 8'(g % 4) : 8'(g % 4);
            end
            else
            begin
              kk = 4'(g % tpg_pkg::GROUP_LANES);
              wbits = {4'hF - kk, kk, 4'h1, 4'hF - kk, kk, 4'h2, 4'hF - kk, kk, 4'h3,
                4'hF - kk, kk, 4'h4};
              if (st_ff.oct_idx < 3'h6)
              begin
                oct = wbits[47 - 8*int'(st_ff.oct_idx) -: 8];
              end
              else if (st_ff.oct_idx == 3'h6)
              begin
                oct = {4'hF - kk, kk};
              end
              else
              begin
                oct = {4'h5, tpg_pkg::TAIL_NIBBLE};
              end
            end
            nxt_st.word[g*8 +: 8] = lane_en[g] ? oct : 8'h00;
          end
        end
        tpg_pkg::TM_D21:
        begin
          nxt_st.valid = 1'b1;
          for (g = 0; g < LANES; g++)
          begin
            nxt_st.word[g*8 +: 8] = lane_en[g] ? tpg_pkg::D21_5 : 8'h00;
          end
        end
        tpg_pkg::TM_K28:
        begin
          nxt_st.valid = !enc_64b66b;
          for (g = 0; g < LANES; g++)
          begin
            nxt_st.word[g*8 +: 8] = lane_en[g] ? tpg_pkg::K28_5 : 8'h00;
            nxt_st.k[g] = lane_en[g];
          end
        end
        tpg_pkg::TM_RPAT:
        begin
          nxt_st.valid = !enc_64b66b;
          for (g = 0; g < LANES; g++)
          begin
            nxt_st.word[g*8 +: 8] = lane_en[g] ? tpg_pkg::RPAT_TABLE[st_ff.rpat_idx] : 8'h00;
          end
        end
        default:
        begin
          nxt_st.valid = 1'b0;
        end
      endcase
      // counters step on every accepted octet
      if (nxt_st.valid)
      begin
        nxt_st.rpat_idx = (st_ff.rpat_idx == 4'(tpg_pkg::RPAT_LEN - 1)) ? 4'h0
          : st_ff.rpat_idx + 4'h1;
        nxt_st.oct_idx = n12_mode ? st_ff.oct_idx + 3'h1 : 3'h0;
        if (!n12_mode || st_ff.oct_idx == 3'h7)
        begin
          nxt_st.frame_ph = ~st_ff.frame_ph;
        end
      end
    end
    if (mode == tpg_pkg::TM_SHORT && !tp_run)
    begin
      nxt_st.oct_idx = 3'h0;
      nxt_st.frame_ph = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // a stalled sink fills the buffer, then stalls pattern steps and samples
  tpg_buf2 #(
    .WIDTH(LANES*8 + LANES)
  ) u_buf (
    .clk(clk),
    .rst(rst),
    .in_valid(st_ff.valid),
    .in_ready(buf_in_ready),
    .in_data({st_ff.k, st_ff.word}),
    .out_valid(lane_valid),
    .out_ready(lane_ready),
    .out_data(buf_out)
  );

  assign lane_octets = buf_out[LANES*8-1:0];
  assign lane_is_k = buf_out[LANES*8 +: LANES];
  assign sample_ready = buf_in_ready && (mode == tpg_pkg::TM_OFF);
  assign ila_repeat = st_ff.ila_rep;
  assign restart_cgs = st_ff.cgs;
endmodule

// *** tb/tpg_props.sv ***
// Purpose: port-level checks of the test-pattern generator
// Assumes: select changes only while reset is held
// Notes: bound onto every instance of the generator
`timescale 1ns/1ns
module tpg_props #(
  parameter int LANES = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] test_pattern_select,
  input wire logic enc_64b66b,
  input wire logic [4:0] active_lanes,
  input wire logic ila_done,
  input wire logic sync_request,
  input wire logic sample_ready,
  input wire logic [LANES*8-1:0] lane_octets,
  input wire logic lane_valid,
  input wire logic lane_ready,
  input wire logic [LANES-1:0] lane_is_k,
  input wire logic ila_repeat,
  input wire logic restart_cgs
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_HOLD: assert property (
    lane_valid && !lane_ready |=> lane_valid && $stable(lane_octets)) else $error("stall");
  AST_ILA: assert property (
    (test_pattern_select == 3'h4 && !enc_64b66b)[*2] |-> ila_repeat) else $error("ila");
  AST_CGS: assert property (
    ila_repeat && test_pattern_select == 3'h4 && sync_request |=> restart_cgs) else $error("cgs");
  AST_NO_CGS: assert property (
    !sync_request |=> !restart_cgs) else $error("cgs idle");
  AST_D21: assert property (
    lane_valid && test_pattern_select == 3'h2 |-> lane_octets[7:0] == tpg_pkg::D21_5)
    else $error("d21");
  AST_K28: assert property (
    lane_valid && test_pattern_select == 3'h3 |-> lane_octets[7:0] == tpg_pkg::K28_5
    && lane_is_k[0]) else $error("k28");
  AST_IDLE: assert property (
    lane_valid && test_pattern_select != 3'h0 && active_lanes == 5'h1
    |-> lane_octets[LANES*8-1:8] == '0) else $error("idle lane");
  AST_READY: assert property (
    test_pattern_select != 3'h0 |-> !sample_ready) else $error("ready");
  AST_RPAT64: assert property (
    enc_64b66b && test_pattern_select == 3'h5 |-> !lane_valid) else $error("rpat");
  AST_START: assert property (
    (test_pattern_select == 3'h1 && !enc_64b66b && !ila_done)[*4] |-> !lane_valid)
    else $error("start");
endmodule
bind jesd_link_test_pattern_gen tpg_props #(.LANES(LANES)) u_props (.*);

// *** tb/tpg_rx.sv ***
// Purpose: receiver model at the far end of the lanes
// Assumes: stall and want_sync come from the bench
// Notes: ready drops at once so a stall lands mid-stream
`timescale 1ns/1ns
module tpg_rx (
  input wire logic clk,
  input wire logic stall,
  input wire logic want_sync,
  output logic lane_ready,
  output logic sync_request
);
  assign lane_ready = !stall;
  initial sync_request = 1'h0;
  always @(posedge clk)
    sync_request <= #1 want_sync;
endmodule

// *** tb/tb_top.sv ***
// Purpose: self-checking bench for the test-pattern generator
// Assumes: select changes only inside a reset
// Notes: rows hold plain modes, hand tests follow
`timescale 1ns/1ns
module tb_top;
  `define CHK(n, e, s) if ((s) !== (e)) begin n_mismatch++; \
    $display("[FAIL] %s exp %h got %h", n, e, s); end num_checks++;
  logic clk = 0, rst = 1, enc_64b66b = 0, n12_mode = 0, serdes_ready = 0, ila_done = 0;
  logic data_enc_state = 0, sample_valid = 1, stall = 0, want_sync = 0;
  logic sample_ready, lane_valid, lane_ready, ila_repeat, restart_cgs, sync_request;
  logic [2:0] test_pattern_select = 0;
  logic [4:0] active_lanes = 5'h10;
  logic [127:0] sample_octets = {16{8'h5A}}, lane_octets, w0, w1;
  logic [15:0] lane_is_k, got;
  logic [63:0] n12_exp = 64'hE11E12E13E14E150;
  int n_mismatch = 0, num_checks = 0;
  typedef struct {logic [2:0] sel; logic enc; logic [4:0] lanes; int ln; logic [15:0] exp;} row_t;
  row_t rows[7] = '{'{3'h0, 1'h0, 5'h10, 2, 16'h5A5A}, '{3'h1, 1'h0, 5'h10, 1, 16'h01FE},
    '{3'h1, 1'h1, 5'h10, 9, 16'h01FE}, '{3'h2, 1'h0, 5'h10, 0, 16'hB5B5},
    '{3'h2, 1'h1, 5'h01, 0, 16'hB5B5}, '{3'h3, 1'h0, 5'h04, 3, 16'hBCBC},
    '{3'h5, 1'h0, 5'h10, 7, 16'h2347}};
  // rpat runs from reset release with a ready sink, so the bench meets octets 2 and 3
  initial forever #20 clk = ~clk;
  jesd_link_test_pattern_gen uut (.*);
  tpg_rx rx (.*);
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // mode is changed only while the link is held in reset
  task automatic restart(input logic [2:0] s, input logic e, input logic [4:0] n);
    #1 rst = 1'h1;
    {test_pattern_select, enc_64b66b, active_lanes} = {s, e, n};
    {serdes_ready, ila_done, data_enc_state} = 3'h0;
    repeat (6) @(posedge clk);
    #1 rst = 1'h0;
    repeat (4) @(posedge clk);
    if (s == 3'h1)
      `CHK("early word", 1'h0, lane_valid)
    #1 {serdes_ready, ila_done, data_enc_state} = 3'h7;
  endtask
  task automatic get_word(output logic [127:0] o);
    int t;
    @(posedge clk);
    for (t = 0; t < 60 && !(lane_valid === 1'h1 && lane_ready === 1'h1); t++)
      @(posedge clk);
    `CHK("word wait", 1'h1, lane_valid && lane_ready)
    o = lane_octets;
  endtask
  initial
  begin
    #800000 n_mismatch++;
    finish_test();
  end
  initial
  begin
    for (int i = 0; i < 7; i++)
    begin
      restart(rows[i].sel, rows[i].enc, rows[i].lanes);
      get_word(w0);
      get_word(w1);
      got = {w0[rows[i].ln*8 +: 8], w1[rows[i].ln*8 +: 8]};
      `CHK("row", rows[i].exp, got)
    end
    // one word per stall release, so any lost or doubled word breaks the order
    restart(3'h1, 1'h0, 5'h10);
    for (int k = 0; k < 8; k++)
    begin
      #1 stall = 1'h1;
      repeat (4) @(posedge clk);
      #1 stall = 1'h0;
      get_word(w0);
      `CHK("stall seq", k[0] ? 8'hFF : 8'h00, w0[7:0])
    end
    #1 stall = 1'h0;
    n12_mode = 1'h1;
    restart(3'h1, 1'h0, 5'h10);
    for (int o = 0; o < 8; o++)
    begin
      get_word(w0);
      `CHK("n12 octet", {2{n12_exp[63-8*o -: 8]}}, {w0[15:8], w0[79:72]})
    end
    #1 n12_mode = 1'h0;
    restart(3'h4, 1'h0, 5'h10);
    #1 want_sync = 1'h1;
    repeat (3) @(posedge clk);
    `CHK("ila sync", 2'h3, {ila_repeat, restart_cgs})
    #1 want_sync = 1'h0;
    restart(3'h5, 1'h1, 5'h10);
    repeat (10) @(posedge clk);
    `CHK("rpat on 64b", 1'h0, lane_valid)
    finish_test();
  end
endmodule
